// file: core/adcdm_demux.sv
// How it works
// R1: Sample captured one fixed stage after edge
// R2: One 8-bit result per conversion forwarded
// R3: Offset binary codes passed through unchanged
// R4: Split enable low forces full-rate mode
// R5: Rate select picks paired or decimate
// R6: Full rate: secondary repeats primary, one later
// R7: Sampling clock at most 500Msps in full-rate
// R8: Secondary unpowered: true and complement high
// R9: Paired mode: one word per two samples
// R10: Pairs presented together on strobe rising edge
// R11: Secondary older sample, primary newer sample
// R12: Board powers secondary port in paired mode
// R13: Data changes with strobe rise; capture latches
// R14: Decimate drops alternate samples, quarter rate
// R15: Paired/decimate: flag over-range on either port
// R16: Full rate: flag over-range on primary only
// R17: Sync input restarts phase, echoed on output
// R18: Data, flag and strobe share one edge
`timescale 1ns/100ps
`default_nettype none

module adcdm_demux
  import adcdm_pkg::*;
#(
  parameter int CODE_W = ADCDM_CODE_W,
  parameter int DEPTH  = ADCDM_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              samp_clk,
  input  wire logic [CODE_W-1:0] sample_code,
  input  wire logic              sample_over,
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire logic              split_enable,
  input  wire logic              rate_select,
  input  wire logic              second_port_power,
  input  wire logic              demux_sync_in,
  output logic                   demux_sync_out,
  output logic [CODE_W-1:0]      primary_word,
  output logic [CODE_W-1:0]      primary_word_comp,
  output logic [CODE_W-1:0]      secondary_word,
  output logic [CODE_W-1:0]      secondary_word_comp,
  output logic                   over_range_flag,
  output logic                   output_strobe
);
  localparam int WW = CODE_W + 1;
  adcdm_stream_if #(.W(WW)) cap_s ();
  adcdm_stream_if #(.W(WW)) dmx_s ();

  logic [WW-1:0] cap_r;
  logic          cap_vld_r;
  // R1: fixed capture stage
  // Back-pressure from the buffer stalls the capture register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_r     <= '0;
      cap_vld_r <= 1'b0;
    end else if (sample_ready) begin
      // R2: one word per sample
      // R3: code kept in offset binary
      cap_r     <= {sample_over, sample_code};
      cap_vld_r <= sample_valid;
    end
  end

  assign sample_ready = !cap_vld_r || cap_s.ready;
  assign cap_s.valid  = cap_vld_r;
  assign cap_s.data   = cap_r;

  adcdm_fifo #(
    .W     (WW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk    (clk),
    .arst_n (arst_n),
    .in_s   (cap_s),
    .out_s  (dmx_s)
  );

  // Static pins: three stages, a change counts once stages 2 and 3 agree
  logic [ADCDM_PIN_N-1:0] pin_raw;
  logic [ADCDM_PIN_N-1:0] pin_s1_r;
  logic [ADCDM_PIN_N-1:0] pin_s2_r;
  logic [ADCDM_PIN_N-1:0] pin_s3_r;
  logic [ADCDM_PIN_N-1:0] pin_r;

  assign pin_raw[ADCDM_PIN_SPLIT] = split_enable;
  assign pin_raw[ADCDM_PIN_RATE]  = rate_select;
  assign pin_raw[ADCDM_PIN_SYNC]  = demux_sync_in;
  for (genvar i = 0; i < ADCDM_PIN_N; i++) begin : g_pin
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pin_s1_r[i] <= 1'b0;
        pin_s2_r[i] <= 1'b0;
        pin_s3_r[i] <= 1'b0;
        pin_r[i]    <= 1'b0;
      end else begin
        pin_s1_r[i] <= pin_raw[i];
        pin_s2_r[i] <= pin_s1_r[i];
        pin_s3_r[i] <= pin_s2_r[i];
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  adcdm_mode_t mode;
  logic        sync_rise;
  logic        sync_prev_r;
  // R4: split disabled means full rate
  // R5: rate select picks the divided mode
  always_comb begin
    if (!pin_r[ADCDM_PIN_SPLIT]) begin
      mode = ADCDM_FULL;
    end else if (pin_r[ADCDM_PIN_RATE]) begin
      mode = ADCDM_DECIM;
    end else begin
      mode = ADCDM_PAIRED;
    end
  end

  assign sync_rise = pin_r[ADCDM_PIN_SYNC] && !sync_prev_r;

  // Demultiplexer state
  logic [1:0]        ph_r;
  logic [CODE_W-1:0] old_code_r;
  logic              old_over_r;
  logic [CODE_W-1:0] head_code;
  logic              head_over;
  logic              emit;
  logic              keep;
  logic              take;
  logic              busy_r;
  logic              req_tgl_r;
  logic              ack_new;
  logic [CODE_W-1:0] b_pri_r;
  logic [CODE_W-1:0] b_sec_r;
  logic              b_over_r;

  assign head_code = dmx_s.data[CODE_W-1:0];
  assign head_over = dmx_s.data[CODE_W];
  // Decide whether the head sample completes a word or is held as older
  always_comb begin
    emit = 1'b0;
    keep = 1'b0;
    unique case (mode)
      ADCDM_FULL: begin
        emit = 1'b1;
        keep = 1'b1;
      end
      ADCDM_PAIRED: begin
        // R9: word every second sample
        emit = ph_r[0];
        keep = !ph_r[0];
      end
      ADCDM_DECIM: begin
        // R14: odd phases are dropped
        emit = (ph_r == ADCDM_PH_THIRD);
        keep = (ph_r == ADCDM_PH_FIRST);
      end
    endcase
  end

  // A completing sample waits while the previous word is still crossing
  assign dmx_s.ready = !(emit && busy_r);
  assign take        = dmx_s.valid && dmx_s.ready;

  // R17: sync restarts the pair phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r           <= ADCDM_PH_FIRST;
      sync_prev_r    <= 1'b0;
      demux_sync_out <= 1'b0;
    end else begin
      sync_prev_r    <= pin_r[ADCDM_PIN_SYNC];
      // R17: echo for further converters
      demux_sync_out <= sync_rise;
      if (sync_rise) begin
        ph_r <= ADCDM_PH_FIRST;
      end else if (take) begin
        ph_r <= ph_r + ADCDM_PH_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      old_code_r <= '0;
      old_over_r <= 1'b0;
    end else if (take && keep) begin
      old_code_r <= head_code;
      old_over_r <= head_over;
    end
  end

  // Word bundle held stable until the link side acknowledges it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      b_pri_r   <= '0;
      b_sec_r   <= '0;
      b_over_r  <= 1'b0;
      req_tgl_r <= 1'b0;
    end else if (take && emit) begin
      // R6: secondary is the previous sample
      // R11: older on secondary, newer on primary
      b_pri_r   <= head_code;
      b_sec_r   <= old_code_r;
      req_tgl_r <= !req_tgl_r;
      // R16: full rate flags primary only
      // R15: divided modes flag either port
      b_over_r  <= (mode == ADCDM_FULL) ? head_over
                                        : (head_over || old_over_r);
    end
  end

  // Busy cannot be set and cleared together: emit needs busy low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (take && emit) begin
      busy_r <= 1'b1;
    end else if (ack_new) begin
      busy_r <= 1'b0;
    end
  end

  // Acknowledge toggle back from the link domain
  logic ack_tgl_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_s3_r;
  logic ack_seen_r;
  assign ack_new = (ack_s2_r == ack_s3_r) && (ack_s3_r != ack_seen_r);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_s1_r   <= 1'b0;
      ack_s2_r   <= 1'b0;
      ack_s3_r   <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
      if (ack_new) begin
        ack_seen_r <= ack_s3_r;
      end
    end
  end

  // Link side, on the sampling clock
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic req_new;
  logic pw_s1_r;
  logic pw_s2_r;
  logic pw_s3_r;
  logic pw_r;
  logic [CODE_W-1:0] sec_r;
  logic [CODE_W-1:0] sec_nxt;
  assign req_new = (req_s2_r == req_s3_r) && (req_s3_r != ack_tgl_r);
  // R10: secondary joins its pair on the strobe edge
  assign sec_nxt = req_new ? b_sec_r : sec_r;

  always_ff @(posedge samp_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (req_new) begin
        ack_tgl_r <= req_s3_r;
      end
    end
  end

  // R13: data changes with the strobe rise
  // R18: word, flag and strobe on one edge
  always_ff @(posedge samp_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_word      <= '0;
      primary_word_comp <= '1;
      sec_r             <= '0;
      over_range_flag   <= 1'b0;
      output_strobe     <= 1'b0;
    end else begin
      output_strobe <= req_new;
      if (req_new) begin
        primary_word      <= b_pri_r;
        primary_word_comp <= ~b_pri_r;
        sec_r             <= b_sec_r;
        over_range_flag   <= b_over_r;
      end
    end
  end

  // Port power pin sampled on the link clock it gates
  always_ff @(posedge samp_clk or negedge arst_n) begin
    if (!arst_n) begin
      pw_s1_r <= 1'b0;
      pw_s2_r <= 1'b0;
      pw_s3_r <= 1'b0;
      pw_r    <= 1'b0;
    end else begin
      pw_s1_r <= second_port_power;
      pw_s2_r <= pw_s1_r;
      pw_s3_r <= pw_s2_r;
      if (pw_s2_r == pw_s3_r) begin
        pw_r <= pw_s3_r;
      end
    end
  end

  // R8: unpowered port rests high on both lines
  always_ff @(posedge samp_clk or negedge arst_n) begin
    if (!arst_n) begin
      secondary_word      <= '1;
      secondary_word_comp <= '1;
    end else begin
      secondary_word      <= pw_r ? sec_nxt : '1;
      secondary_word_comp <= pw_r ? ~sec_nxt : '1;
    end
  end

endmodule

`default_nettype wire

// file: core/adcdm_pkg.sv
package adcdm_pkg;

  // Converter word and its over-range bit
  localparam int ADCDM_CODE_W   = 8;
  localparam int ADCDM_WORD_W   = ADCDM_CODE_W + 1;
  localparam int ADCDM_OVER_BIT = ADCDM_CODE_W;

  // Sample buffer between capture and demultiplexer
  localparam int ADCDM_FIFO_DEPTH = 16;

  // Static control pins, sampled in the system clock domain
  localparam int ADCDM_PIN_N     = 3;
  localparam int ADCDM_PIN_SPLIT = 0;
  localparam int ADCDM_PIN_RATE  = 1;
  localparam int ADCDM_PIN_SYNC  = 2;

  // Sample phase within a group of four inputs
  localparam logic [1:0] ADCDM_PH_FIRST = 2'h0;
  localparam logic [1:0] ADCDM_PH_THIRD = 2'h2;
  localparam logic [1:0] ADCDM_PH_STEP  = 2'h1;

  typedef enum logic [1:0] {
    ADCDM_FULL   = 2'b00,
    ADCDM_PAIRED = 2'b01,
    ADCDM_DECIM  = 2'b10
  } adcdm_mode_t;

endpackage

// file: core/adcdm_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

interface adcdm_stream_if #(
  parameter int W = 9
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: core/adcdm_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module adcdm_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic    clk,
  input  wire logic    arst_n,
  adcdm_stream_if.snk  in_s,
  adcdm_stream_if.src  out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IX = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_s.ready  = (count_r != FULL_CNT);
  assign out_s.valid = (count_r != '0);
  assign out_s.data  = mem[rd_ptr_r];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_IX) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_IX) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/adcdm_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adcdm_sva
  import adcdm_pkg::*;
#(
  parameter int CODE_W = ADCDM_CODE_W,
  parameter int DEPTH  = ADCDM_FIFO_DEPTH
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              samp_clk,
  input wire logic              second_port_power,
  input wire logic              demux_sync_in,
  input wire logic              demux_sync_out,
  input wire logic [CODE_W-1:0] primary_word,
  input wire logic [CODE_W-1:0] primary_word_comp,
  input wire logic [CODE_W-1:0] secondary_word,
  input wire logic [CODE_W-1:0] secondary_word_comp,
  input wire logic              over_range_flag,
  input wire logic              output_strobe
);
  property p_strobe_pulse;
    @(posedge samp_clk) disable iff (!arst_n)
      output_strobe |=> !output_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one cycle");
  property p_pri_hold;
    @(posedge samp_clk) disable iff (!arst_n)
      !output_strobe |-> $stable(primary_word);
  endproperty
  a_pri_hold: assert property (p_pri_hold)
    else $error("primary changed without strobe");
  property p_flag_hold;
    @(posedge samp_clk) disable iff (!arst_n)
      !output_strobe |-> $stable(over_range_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag changed without strobe");
  property p_pri_comp;
    @(posedge samp_clk) disable iff (!arst_n)
      primary_word_comp == ~primary_word;
  endproperty
  a_pri_comp: assert property (p_pri_comp)
    else $error("primary complement wrong");
  // Pin passes a synchroniser, so allow it to settle first
  property p_sec_off;
    @(posedge samp_clk) disable iff (!arst_n)
      !second_port_power [*8] |->
        secondary_word == '1 && secondary_word_comp == '1;
  endproperty
  a_sec_off: assert property (p_sec_off)
    else $error("unpowered secondary not high");
  property p_sec_comp;
    @(posedge samp_clk) disable iff (!arst_n)
      second_port_power [*8] |-> secondary_word_comp == ~secondary_word;
  endproperty
  a_sec_comp: assert property (p_sec_comp)
    else $error("secondary complement wrong");
  property p_sync_pulse;
    @(posedge clk) disable iff (!arst_n)
      demux_sync_out |=> !demux_sync_out;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync output longer than one cycle");
  property p_sync_echo;
    @(posedge clk) disable iff (!arst_n)
      $rose(demux_sync_in) |-> ##[2:8] demux_sync_out;
  endproperty
  a_sync_echo: assert property (p_sync_echo)
    else $error("sync output missing");
  c_flag: cover property (@(posedge samp_clk) output_strobe && over_range_flag);
  c_sync: cover property (@(posedge clk) demux_sync_out);
  c_off: cover property (@(posedge samp_clk)
    output_strobe && !second_port_power);
endmodule
bind adcdm_demux adcdm_sva #(.CODE_W(CODE_W), .DEPTH(DEPTH)) i_adcdm_sva (
  .clk, .arst_n, .samp_clk, .second_port_power, .demux_sync_in,
  .demux_sync_out, .primary_word, .primary_word_comp, .secondary_word,
  .secondary_word_comp, .over_range_flag, .output_strobe);
`default_nettype wire

// file: tb/adcdm_capture.sv
`timescale 1ns/100ps
`default_nettype none
module adcdm_capture
  import adcdm_pkg::*;
(
  input wire logic                    samp_clk,
  input wire logic                    arst_n,
  input wire logic [ADCDM_CODE_W-1:0] primary_word,
  input wire logic [ADCDM_CODE_W-1:0] secondary_word,
  input wire logic                    over_range_flag,
  input wire logic                    output_strobe
);
  logic [ADCDM_WORD_W-1:0] pri_q[$];
  logic [ADCDM_CODE_W-1:0] sec_q[$];
  always @(posedge samp_clk) begin
    if (arst_n && output_strobe) begin
      pri_q.push_back({over_range_flag, primary_word});
      sec_q.push_back(secondary_word);
    end
  end
endmodule
`default_nettype wire

// file: tb/adcdm_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcdm_tb_top
  import adcdm_pkg::*;
;
  logic       clk, arst_n, samp_clk, sample_valid, sample_over, sample_ready;
  logic       split_enable, rate_select, second_port_power, demux_sync_in;
  logic       demux_sync_out, over_range_flag, output_strobe;
  logic [7:0] sample_code, primary_word, secondary_word;
  logic [8:0] sq[$];
  int         failures, total_checks, stalls;

  adcdm_demux i_adcdm_demux (.clk, .arst_n, .samp_clk, .sample_code,
    .sample_over, .sample_valid, .sample_ready, .split_enable, .rate_select,
    .second_port_power, .demux_sync_in, .demux_sync_out, .primary_word,
    .primary_word_comp(), .secondary_word, .secondary_word_comp(),
    .over_range_flag, .output_strobe);
  adcdm_capture i_adcdm_capture (.samp_clk, .arst_n, .primary_word,
    .secondary_word, .over_range_flag, .output_strobe);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    samp_clk = 1'b0;
    #3.3;
    forever #40 samp_clk = ~samp_clk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Valid stays up between calls so bursts run back to back
  task automatic send(input int i);
    logic ok;
    sample_code = i[0] ? ~(i[7:0] - 8'h01) : i[7:0];
    sample_over = (i % 3 == 1);
    sample_valid = 1'b1;
    for (int n = 0; n < 4000; n++) begin
      #6;
      ok = sample_ready;
      @(posedge clk);
      #1;
      if (ok === 1'b1) break;
      stalls++;
    end
    sq.push_back({sample_over, sample_code});
  endtask

  task automatic run(input logic sp, input logic rt, input logic pw,
                     input int ns);
    int b, nw, st, o, m;
    logic [8:0] e;
    b = i_adcdm_capture.pri_q.size();
    st = sp ? (rt ? 4 : 2) : 1;
    nw = ns / st;
    split_enable = sp;
    rate_select = rt;
    second_port_power = pw;
    repeat (100) @(posedge clk);
    #1 demux_sync_in = 1'b1;
    repeat (6) @(posedge clk);
    #1 demux_sync_in = 1'b0;
    repeat (10) @(posedge clk);
    #1 sq.delete();
    for (int i = 0; i < ns; i++) send(i);
    sample_valid = 1'b0;
    for (int k = 0; k < 40000; k++) begin
      if (i_adcdm_capture.pri_q.size() >= b + nw) break;
      @(posedge clk);
    end
    repeat (200) @(posedge clk);
    #1;
    chk("words", nw, i_adcdm_capture.pri_q.size() - b);
    for (int k = 0; k < nw; k++) begin
      m = k * st + st / 2;
      o = (st == 1) ? k - 1 : k * st;
      e = sq[m];
      if (st > 1) e[8] = sq[m][8] | sq[o][8];
      chk("primary", e, i_adcdm_capture.pri_q[b + k]);
      e = pw ? {1'b0, sq[o][7:0]} : 9'h0ff;
      if (o >= 0 || !pw)
        chk("secondary", e, {1'b0, i_adcdm_capture.sec_q[b + k]});
    end
  endtask

  initial begin
    {sample_valid, sample_over, split_enable, rate_select} = 4'h0;
    demux_sync_in = 1'b0;
    second_port_power = 1'b1;
    sample_code = 8'h00;
    arst_n = 1'b0;
    repeat (20) @(posedge clk);
    chk("reset", 9'h0ff, {output_strobe, secondary_word});
    #1 arst_n = 1'b1;
    run(1'b0, 1'b0, 1'b1, 7);
    run(1'b1, 1'b0, 1'b1, 8);
    run(1'b1, 1'b1, 1'b1, 64);
    chk("refused", 9'h001, {8'h00, stalls > 0});
    run(1'b0, 1'b1, 1'b1, 4);
    run(1'b0, 1'b0, 1'b0, 4);
    conclude();
  end

  initial begin
    #600000;
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
